// ---- rwc_asserts.sv ----
// Port assertions for the reset and wake control block
`timescale 1ns/1ns
module rwc_asserts
    import rwc_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Register writes
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    // Core side inputs
    input rwc_core_ev_type core_ev,
    input wire logic       irq_flag_enabled,
    input wire logic       global_irq_enable,
    input wire logic       watchdog_timeout,
    // Outputs watched
    input wire logic       core_reset,
    input wire logic       cpu_run,
    input wire logic       branch_vector,
    input wire logic       run_from_rc,
    input wire logic       watchdog_clear,
    input wire logic       priority_levels_enable,
    input wire logic       external_clear_pin_oe,
    input wire logic [3:0] reset_cause
);
    logic        run_q, lp, woke, next_lp, next_woke;
    logic [11:0] wake_cnt, next_wake_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Low power as seen at the ports; a reset ends it without a wake
    always_comb begin
        next_lp       = ~core_reset & ~cpu_run & (lp | run_q);
        next_woke     = next_lp & (woke | irq_flag_enabled | watchdog_timeout);
        next_wake_cnt = woke ? wake_cnt + 12'h001 : 12'h000;
    end

    // Helper registers
    always_ff @(posedge clk) begin
        if (rst) begin
            run_q    <= 1'b0;
            lp       <= 1'b0;
            woke     <= 1'b0;
            wake_cnt <= 12'h000;
        end else begin
            run_q    <= cpu_run;
            lp       <= next_lp;
            woke     <= next_woke;
            wake_cnt <= next_wake_cnt;
        end
    end

    a_pin_not_driven: assert property (external_clear_pin_oe == 1'b0)
        else $error("clear pin driven");
    a_prio_follows_write: assert property (reg_wr && reg_addr == RWC_OFF_CAUSE
        |=> priority_levels_enable == $past(reg_wdata[RWC_BIT_PRIO])) else $error("priority enable wrong");
    a_wdclr_after_instr: assert property (cpu_run && (core_ev.sleep_instr || core_ev.watchdog_clear_instr)
        |=> watchdog_clear) else $error("watchdog not cleared");
    a_instr_reset_cause: assert property (cpu_run && core_ev.reset_instr
        |-> ##[1:4] (core_reset && reset_cause == 4'h6)) else $error("instruction reset missing");
    a_watchdog_run_reset: assert property (cpu_run && watchdog_timeout
        |-> ##[1:4] (core_reset && reset_cause == 4'h4)) else $error("watchdog reset missing");
    a_wake_has_cause: assert property ($rose(cpu_run) && lp |-> woke)
        else $error("wake without cause");
    a_ready_delay: assert property ($rose(cpu_run) && lp |-> wake_cnt >= 12'(RWC_CPU_READY_CYC))
        else $error("ready delay too short");
    a_branch_needs_enable: assert property (branch_vector |-> $rose(cpu_run) && global_irq_enable)
        else $error("branch without global enable");
    a_poweron_cause: assert property ($fell(rst) |-> core_reset && reset_cause == 4'h1)
        else $error("power-on cause wrong");
    a_rc_on_reset: assert property ($rose(core_reset) && lp |-> ##[0:2] run_from_rc)
        else $error("not on internal RC");

    c_wake: cover property ($rose(cpu_run) && lp);
    c_branch: cover property (branch_vector);
    c_reset: cover property ($rose(core_reset));
endmodule : rwc_asserts

bind rwc_top rwc_asserts i_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .core_ev(core_ev), .irq_flag_enabled(irq_flag_enabled),
    .global_irq_enable(global_irq_enable), .watchdog_timeout(watchdog_timeout), .core_reset(core_reset),
    .cpu_run(cpu_run), .branch_vector(branch_vector), .run_from_rc(run_from_rc),
    .watchdog_clear(watchdog_clear), .priority_levels_enable(priority_levels_enable),
    .external_clear_pin_oe(external_clear_pin_oe), .reset_cause(reset_cause));

// ---- rwc_pins.sv ----
// Board side model: clear pin driver, supply monitor, RC oscillator
`timescale 1ns/1ns
module rwc_pins (
    // Bench clock
    input wire logic clk,
    // Board signals
    output logic     pin_n,
    output logic     sup_n,
    output logic     rc_tick
);
    // Pin pulled up, supply good at start
    initial begin
        pin_n   = 1'b1;
        sup_n   = 1'b1;
        rc_tick = 1'b0;
    end

    // oscillator runs free, unrelated in phase to clk
    always #7 rc_tick = ~rc_tick;

    // hold the clear pin low for n cycles
    task automatic pin_low(input int n);
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (n) @(posedge clk);
        pin_n <= 1'b1;
    endtask : pin_low

    // supply below threshold for n cycles
    task automatic dip(input int n);
        @(posedge clk);
        sup_n <= 1'b0;
        repeat (n) @(posedge clk);
        sup_n <= 1'b1;
    endtask : dip
endmodule : rwc_pins

// ---- rwc_pkg.sv ----
// Package for the reset and wake control block: offsets, fields, timing, types
package rwc_pkg;

    // Register offsets on the plain register port
    localparam logic [1:0] RWC_OFF_CAUSE   = 2'h0;
    localparam logic [1:0] RWC_OFF_STATUS  = 2'h1;
    localparam logic [1:0] RWC_OFF_CONFIG  = 2'h2;

    // Reset cause register field positions
    localparam int RWC_BIT_PRIO   = 7;
    localparam int RWC_BIT_RI     = 4;
    localparam int RWC_BIT_TO     = 3;
    localparam int RWC_BIT_PD     = 2;
    localparam int RWC_BIT_POR    = 1;
    localparam int RWC_BIT_BOR    = 0;

    // Config register field positions (status/config are block-local)
    localparam int RWC_CFG_FSCM   = 0;
    localparam int RWC_CFG_EXTCLK = 1;
    localparam int RWC_CFG_REGEN  = 2;
    localparam int RWC_CFG_BOREN  = 3;

    // Values after power-on for the reset cause and config registers
    localparam logic [7:0] RWC_CAUSE_POR_VAL = 8'h1c;
    localparam logic [7:0] RWC_CONFIG_RST    = 8'h0c;

    // Timing figures
    localparam int RWC_CLK_MHZ          = 250;
    localparam int RWC_CPU_READY_NS     = 200;
    localparam int RWC_CPU_READY_CYC    = (RWC_CPU_READY_NS * RWC_CLK_MHZ + 999) / 1000;
    localparam int RWC_OST_CYCLES       = 1024;
    localparam int RWC_POWERUP_TIMER_BITS        = 11;
    localparam int RWC_POWERUP_TIMER_TICKS       = 2048;
    localparam int RWC_FILTER_CYC       = 4;

    // Power mode of the core
    typedef enum logic [1:0] {
        RWC_MODE_RUN      = 2'b00,
        RWC_MODE_SLEEP    = 2'b01,
        RWC_MODE_IDLE_PRI = 2'b10,
        RWC_MODE_IDLE_OTH = 2'b11
    } rwc_mode_type;

    // Wake sequencer state
    typedef enum logic [2:0] {
        RWC_ST_RUN   = 3'b000,
        RWC_ST_SAVE  = 3'b001,
        RWC_ST_OST   = 3'b010,
        RWC_ST_READY = 3'b011,
        RWC_ST_POWERUP_TIMER  = 3'b100
    } rwc_state_type;

    // Core events from the instruction decoder and monitors
    typedef struct packed {
        logic sleep_instr;
        logic idle_select;
        logic primary_idle_mode;
        logic watchdog_clear_instr;
        logic reset_instr;
        logic stack_full;
        logic stack_underflow;
        logic clock_lost;
    } rwc_core_ev_type;

endpackage : rwc_pkg

// ---- rwc_top.sv ----
// Reset and wake control: reset causes, cause flags, wake sequencing, watchdog clear
`timescale 1ns/1ns
module rwc_top
    import rwc_pkg::*;
(
    // Clock and reset (rst is the power-on reset)
    input  wire logic            clk,
    input  wire logic            rst,
    // Register port
    input  wire logic [1:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata,
    // Pins and analog monitors (asynchronous)
    input  wire logic            external_clear_pin_n,
    input  wire logic            brownout_n,
    input  wire logic            internal_rc_osc_tick,
    // Core events and interrupt state (same clock)
    input  rwc_core_ev_type      core_ev,
    input  wire logic            irq_flag_enabled,
    input  wire logic            global_irq_enable,
    input  wire logic            watchdog_timeout,
    // Core controls
    output logic                 core_reset,
    output logic                 cpu_run,
    output logic                 branch_vector,
    output logic                 run_from_rc,
    output logic                 watchdog_clear,
    output logic                 priority_levels_enable,
    output logic                 external_clear_pin_oe,
    output logic [3:0]           reset_cause
);

    // Two-flop synchronisers on the asynchronous inputs
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic       rc_prev;
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_a  <= 3'h7;
            sync_b  <= 3'h7;
            rc_prev <= 1'b1; // Matches the synchroniser, so no false tick after reset
        end else begin
            sync_a  <= {internal_rc_osc_tick, brownout_n, external_clear_pin_n};
            sync_b  <= sync_a;
            rc_prev <= sync_b[2];
        end
    end
    logic clr_pin_n;
    logic bor_low;
    logic rc_edge;
    assign clr_pin_n = sync_b[0];
    assign bor_low   = ~sync_b[1];
    assign rc_edge   = sync_b[2] & ~rc_prev;

    // State of the block
    logic [7:0]         cause;
    logic [7:0]         config_r;
    rwc_state_type      state;
    rwc_mode_type       mode;
    logic [10:0]        cnt;
    logic [RWC_POWERUP_TIMER_BITS-1:0] powerup_timer;
    logic [2:0]         filt;
    logic               wake_irq;
    logic               in_reset;
    logic [3:0]         cause_code;
    logic               out_cpu_run;
    logic               out_branch;
    logic               out_rc;
    logic               out_wdclr;
    logic [7:0]         rdata;

    logic [7:0]         next_cause;
    logic [7:0]         next_config;
    rwc_state_type      next_state;
    rwc_mode_type       next_mode;
    logic [10:0]        next_cnt;
    logic [RWC_POWERUP_TIMER_BITS-1:0] next_powerup_timer;
    logic [2:0]         next_filt;
    logic               next_wake_irq;
    logic               next_in_reset;
    logic [3:0]         next_cause_code;
    logic               next_cpu_run;
    logic               next_branch;
    logic               next_rc;
    logic               next_wdclr;
    logic [7:0]         next_rdata;

    // Decoded register write, used by several fields
    function automatic logic wr_hit(input logic wr, input logic [1:0] a, input logic [1:0] off);
        wr_hit = wr & (a == off);
    endfunction : wr_hit

    // Next-state logic for flags, sequencer and outputs
    always_comb begin
        logic pin_rst;
        logic bor_rst;
        logic wdt_rst;
        logic low_power;
        logic wake;
        logic cause_wr;
        logic bor_avail;
        pin_rst     = 1'b0;
        bor_rst     = 1'b0;
        wdt_rst     = 1'b0;
        low_power   = 1'b0;
        wake        = 1'b0;
        cause_wr    = wr_hit(reg_wr, reg_addr, RWC_OFF_CAUSE);
        next_cause  = cause;
        next_config = config_r;
        next_state  = state;
        next_mode   = mode;
        next_cnt    = cnt;
        next_powerup_timer   = powerup_timer;
        next_filt   = filt;
        next_wake_irq   = wake_irq;
        next_in_reset   = in_reset;
        next_cause_code = cause_code;
        next_cpu_run    = 1'b0;
        next_branch     = 1'b0;
        next_rc         = out_rc;
        next_wdclr      = 1'b0;
        next_rdata      = 8'h00;

        // Firmware writes: only set-by-firmware bits and the priority bit
        if (cause_wr) begin
            next_cause[RWC_BIT_PRIO] = reg_wdata[RWC_BIT_PRIO];
            next_cause[RWC_BIT_RI]   = cause[RWC_BIT_RI]  | reg_wdata[RWC_BIT_RI];
            next_cause[RWC_BIT_POR]  = cause[RWC_BIT_POR] | reg_wdata[RWC_BIT_POR];
            next_cause[RWC_BIT_BOR]  = cause[RWC_BIT_BOR] | reg_wdata[RWC_BIT_BOR];
        end
        if (wr_hit(reg_wr, reg_addr, RWC_OFF_CONFIG)) begin
            next_config = {4'h0, reg_wdata[3:0]};
        end
        bor_avail = config_r[RWC_CFG_BOREN] & config_r[RWC_CFG_REGEN];

        // clear pin must stay low several cycles to count
        if (!clr_pin_n) begin
            next_filt = (filt == 3'(RWC_FILTER_CYC)) ? filt : filt + 3'h1;
        end else begin
            next_filt = 3'h0;
        end
        pin_rst = (filt == 3'(RWC_FILTER_CYC));
        // brown-out only detected with the BOREN and REGEN config bits both set
        bor_rst = bor_low & bor_avail;
        low_power = (mode != RWC_MODE_RUN);
        wdt_rst = watchdog_timeout & ~low_power & ~in_reset;

        // watchdog clear on sleep, clear instr or clock loss
        next_wdclr = core_ev.sleep_instr | core_ev.watchdog_clear_instr
                   | (core_ev.clock_lost & config_r[RWC_CFG_FSCM]);

        // hardware events drive the TO and PD flags; clears after sets
        if (core_ev.watchdog_clear_instr && !in_reset) begin
            next_cause[RWC_BIT_TO] = 1'b1;
            next_cause[RWC_BIT_PD] = 1'b1;
        end
        if (core_ev.sleep_instr && !in_reset && !low_power) begin
            next_cause[RWC_BIT_TO] = 1'b1;
            next_cause[RWC_BIT_PD] = 1'b0;
            next_mode = !core_ev.idle_select ? RWC_MODE_SLEEP
                      : core_ev.primary_idle_mode ? RWC_MODE_IDLE_PRI : RWC_MODE_IDLE_OTH;
        end
        if (watchdog_timeout && !in_reset) begin
            next_cause[RWC_BIT_TO] = 1'b0;
        end

        // eight reset causes, encoded for the core
        if (bor_rst) begin
            next_cause_code = 4'h5;
            next_cause[RWC_BIT_RI] = 1'b1;
            next_cause[RWC_BIT_TO] = 1'b1;
            next_cause[RWC_BIT_PD] = 1'b1;
            next_cause[RWC_BIT_BOR] = 1'b0;
        end else if (pin_rst && !in_reset) begin
            next_cause_code = low_power ? 4'h3 : 4'h2;
            if (low_power) begin
                next_cause[RWC_BIT_TO] = 1'b1;
                next_cause[RWC_BIT_PD] = 1'b0;
            end
        end else if (wdt_rst) begin
            next_cause_code = 4'h4;
        end else if (core_ev.reset_instr && !in_reset) begin
            next_cause_code = 4'h6;
            next_cause[RWC_BIT_RI] = 1'b0;
        end else if (core_ev.stack_full && !in_reset) begin
            next_cause_code = 4'h7;
        end else if (core_ev.stack_underflow && !in_reset) begin
            next_cause_code = 4'h8;
        end
        // regulator disabled forces brown-out flag low
        if (!config_r[RWC_CFG_REGEN]) begin
            next_cause[RWC_BIT_BOR] = 1'b0;
        end

        // only interrupt, reset or watchdog leave low power
        // enabled interrupt flag starts the exit
        wake = low_power && (irq_flag_enabled || watchdog_timeout);

        case (state)
            RWC_ST_RUN: begin
                next_cpu_run = ~low_power;
                if (wake) begin
                    next_wake_irq = irq_flag_enabled;
                    next_cpu_run  = 1'b0;
                    // start-up timer skipped for either idle mode or ext clock
                    if (mode == RWC_MODE_IDLE_PRI || config_r[RWC_CFG_EXTCLK] || mode != RWC_MODE_SLEEP) begin
                        next_state = RWC_ST_READY;
                        next_cnt   = 11'(RWC_CPU_READY_CYC - 1);
                    end else begin
                        next_state = RWC_ST_OST;
                        next_cnt   = 11'(RWC_OST_CYCLES - 1);
                    end
                end
            end
            RWC_ST_OST: begin
                if (cnt == 11'h000) begin
                    next_state = RWC_ST_READY;
                    next_cnt   = 11'(RWC_CPU_READY_CYC - 1);
                end else begin
                    next_cnt = cnt - 11'h001;
                end
            end
            RWC_ST_READY: begin
                // execution restarts the cycle after the delay
                if (cnt == 11'h000) begin
                    next_state   = RWC_ST_RUN;
                    next_mode    = RWC_MODE_RUN;
                    next_cpu_run = 1'b1;
                    next_branch  = wake_irq & global_irq_enable;
                end else begin
                    next_cnt = cnt - 11'h001;
                end
            end
            RWC_ST_POWERUP_TIMER: begin
                next_cpu_run = 1'b0;
                // count RC ticks, over the full 11-bit range after power-on or brown-out
                if (bor_rst) begin
                    // brown-out in timing restarts the timer
                    next_powerup_timer = '0;
                end else if (powerup_timer == RWC_POWERUP_TIMER_BITS'(RWC_POWERUP_TIMER_TICKS - 1) && rc_edge) begin
                    next_state    = RWC_ST_RUN;
                    next_in_reset = 1'b0;
                    next_cpu_run  = 1'b1;
                end else if (rc_edge) begin
                    next_powerup_timer = powerup_timer + 1'b1;
                end
            end
            default: begin
                next_state = RWC_ST_RUN;
            end
        endcase

        // Any reset overrides the wake sequencer
        if (bor_rst) begin
            next_state    = RWC_ST_POWERUP_TIMER;
            next_in_reset = 1'b1;
            next_powerup_timer     = '0;
            next_mode     = RWC_MODE_RUN;
            next_cpu_run  = 1'b0;
            next_branch   = 1'b0;
            // reset leaves low power on the RC clock
            next_rc       = 1'b1;
        end else if (!in_reset && (pin_rst || wdt_rst || core_ev.reset_instr
                                   || core_ev.stack_full || core_ev.stack_underflow)) begin
            next_state    = RWC_ST_POWERUP_TIMER;
            next_in_reset = 1'b1;
            next_powerup_timer     = RWC_POWERUP_TIMER_BITS'(RWC_POWERUP_TIMER_TICKS - 1);
            next_mode     = RWC_MODE_RUN;
            next_cpu_run  = 1'b0;
            next_branch   = 1'b0;
            // unlike brown-out, these resets force the RC clock only out of low power
            next_rc       = low_power;
        end else if (in_reset && pin_rst) begin
            // Pin held low keeps the core in reset, even if the timer has run out
            next_state   = RWC_ST_POWERUP_TIMER;
            next_cpu_run = 1'b0;
            next_in_reset = 1'b1;
        end

        // Register read data, one cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                RWC_OFF_CAUSE:  next_rdata = {cause[7], 2'b00, cause[4:0]};
                RWC_OFF_STATUS: next_rdata = {cause_code, 1'b0, in_reset, mode};
                RWC_OFF_CONFIG: next_rdata = config_r;
                default:        next_rdata = 8'h00;
            endcase
        end
    end

    // Registers; rst is the power-on reset of the block
    always_ff @(posedge clk) begin
        if (rst) begin
            // power-on clears power-on flag, nothing else does
            cause       <= RWC_CAUSE_POR_VAL;
            config_r    <= RWC_CONFIG_RST;
            state       <= RWC_ST_POWERUP_TIMER;
            mode        <= RWC_MODE_RUN;
            cnt         <= 11'h000;
            powerup_timer        <= '0;
            filt        <= 3'h0;
            wake_irq    <= 1'b0;
            in_reset    <= 1'b1;
            cause_code  <= 4'h1;
            out_cpu_run <= 1'b0;
            out_branch  <= 1'b0;
            out_rc      <= 1'b1;
            out_wdclr   <= 1'b0;
            rdata       <= 8'h00;
        end else begin
            cause       <= next_cause;
            config_r    <= next_config;
            state       <= next_state;
            mode        <= next_mode;
            cnt         <= next_cnt;
            powerup_timer        <= next_powerup_timer;
            filt        <= next_filt;
            wake_irq    <= next_wake_irq;
            in_reset    <= next_in_reset;
            cause_code  <= next_cause_code;
            out_cpu_run <= next_cpu_run;
            out_branch  <= next_branch;
            out_rc      <= next_rc;
            out_wdclr   <= next_wdclr;
            rdata       <= next_rdata;
        end
    end

    // Outputs straight from flops
    assign reg_rdata              = rdata;
    assign core_reset             = in_reset;
    assign cpu_run                = out_cpu_run;
    assign branch_vector          = out_branch;
    assign run_from_rc            = out_rc;
    assign watchdog_clear         = out_wdclr;
    assign priority_levels_enable = cause[RWC_BIT_PRIO];
    assign reset_cause            = cause_code;
    // the clear pin is input only, never driven
    assign external_clear_pin_oe  = 1'b0;

endmodule : rwc_top

// ---- rwc_top_bench.sv ----
// Self-checking bench of the reset and wake control block
`timescale 1ns/1ns
module rwc_top_bench import rwc_pkg::*; ;
    logic            clk, rst, reg_wr, reg_rd, irq_flag_enabled, global_irq_enable, watchdog_timeout;
    logic [1:0]      reg_addr;
    logic [7:0]      reg_wdata, reg_rdata, w, em, mm;
    rwc_core_ev_type core_ev;
    logic            pin_n, sup_n, rc_tick, core_reset, cpu_run, branch_vector, run_from_rc;
    logic [3:0]      reset_cause;
    logic [7:0]      exp_q[$], msk_q[$];
    logic            rd_seen = 1'b0, br_seen = 1'b0;
    int              num_errors, check_count, n;
    integer          seed;
    logic [7:0]      ev_tab[5] = '{8'h00, 8'h08, 8'h04, 8'h02, 8'h00};
    logic [3:0]      code_tab[5] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'h2};
    logic [7:0]      msk_tab[5] = '{8'h08, 8'h10, 8'h00, 8'h00, 8'h00};

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    rwc_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_clear_pin_n(pin_n), .brownout_n(sup_n),
        .internal_rc_osc_tick(rc_tick), .core_ev(core_ev), .irq_flag_enabled(irq_flag_enabled),
        .global_irq_enable(global_irq_enable), .watchdog_timeout(watchdog_timeout), .core_reset(core_reset),
        .cpu_run(cpu_run), .branch_vector(branch_vector), .run_from_rc(run_from_rc), .watchdog_clear(),
        .priority_levels_enable(), .external_clear_pin_oe(), .reset_cause(reset_cause));
    rwc_pins i_pins (.clk(clk), .pin_n(pin_n), .sup_n(sup_n), .rc_tick(rc_tick));

    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk

    // Strobe dropped a cycle before the next request
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic ev(input logic [7:0] e);
        core_ev <= e;
        @(posedge clk);
        core_ev <= '0;
        @(posedge clk);
    endtask : ev

    // Bounded wait on core_reset (sel 1) or cpu_run (sel 0); n gives cycles
    task automatic wait_for(input bit sel, input logic v, input int lim);
        n = 0;
        while (((sel ? core_reset : cpu_run) !== v) && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            $display("[FAIL] wait expected %0d seen timeout", v);
            num_errors++;
            results();
        end
    endtask : wait_for

    // Sleep or idle, then one wake cause; delay measured from the cause
    task automatic nap(input logic [7:0] e, input bit by_wd, input int lo, input int hi);
        ev(e);
        repeat (20) @(posedge clk);
        chk("asleep", 8'h00, {7'h0, cpu_run});
        br_seen = 1'b0;
        if (by_wd)
            watchdog_timeout <= 1'b1;
        else
            irq_flag_enabled <= 1'b1;
        @(posedge clk);
        watchdog_timeout <= 1'b0;
        wait_for(0, 1, 2000);
        irq_flag_enabled <= 1'b0;
        @(posedge clk);
        chk("wake delay", 8'h01, {7'h0, n >= lo && n <= hi});
        chk("no reset", 8'h00, {7'h0, core_reset});
    endtask : nap

    // Read answers against the oldest note; branch pulses remembered
    always @(posedge clk) begin
        if (rd_seen) begin
            em = exp_q.pop_front();
            mm = msk_q.pop_front();
            chk("register read", em & mm, reg_rdata & mm);
        end
        rd_seen <= reg_rd;
        if (branch_vector === 1'b1)
            br_seen = 1'b1;
    end

    // Main sequence
    initial begin
        seed = 32'hf6e6f829;
        {rst, reg_wr, reg_rd, irq_flag_enabled, global_irq_enable, watchdog_timeout} = 6'h20;
        reg_addr    = 2'h0;
        reg_wdata   = 8'h00;
        core_ev     = '0;
        num_errors  = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset code", 8'h01, {4'h0, reset_cause});
        chk("rc clock", 8'h01, {7'h0, run_from_rc});
        rd(RWC_OFF_CAUSE, RWC_CAUSE_POR_VAL, 8'hff);
        rd(RWC_OFF_CONFIG, RWC_CONFIG_RST, 8'hff);
        wait_for(1, 0, 20000);
        wait_for(0, 1, 300);
        w = 8'($random(seed));
        wr(RWC_OFF_CAUSE, w | 8'h13);
        rd(RWC_OFF_CAUSE, {w[7], 7'h1f}, 8'hff);
        wr(RWC_OFF_CAUSE, 8'h00);
        rd(RWC_OFF_CAUSE, 8'h1f, 8'hff);
        rd(2'h3, 8'h00, 8'hff);
        $display("test registers done");
        global_irq_enable <= 1'b1;
        nap(8'h80, 0, 1072, 1110);
        chk("branch", 8'h01, {7'h0, br_seen});
        rd(RWC_OFF_CAUSE, 8'h08, 8'h0c);
        global_irq_enable <= 1'b0;
        wr(RWC_OFF_CONFIG, 8'h0e);
        nap(8'he0, 0, 48, 60);
        chk("branch", 8'h00, {7'h0, br_seen});
        nap(8'h80, 1, 48, 60);
        rd(RWC_OFF_CAUSE, 8'h00, 8'h0c);
        ev(8'h10);
        rd(RWC_OFF_CAUSE, 8'h0c, 8'h0c);
        $display("test wake done");
        for (int i = 0; i < 5; i++) begin
            if (i == 0)
                watchdog_timeout <= 1'b1;
            else if (i < 4)
                core_ev <= ev_tab[i];
            else
                i_pins.pin_low(10);
            @(posedge clk);
            watchdog_timeout <= 1'b0;
            core_ev <= '0;
            wait_for(1, 1, 30);
            chk("reset code", {4'h0, code_tab[i]}, {4'h0, reset_cause});
            chk("rc clock", 8'h00, {7'h0, run_from_rc});
            wait_for(1, 0, 300);
            wait_for(0, 1, 300);
            rd(RWC_OFF_CAUSE, 8'h00, msk_tab[i]);
        end
        i_pins.pin_low(2);
        repeat (20) @(posedge clk);
        chk("short pulse", 8'h00, {7'h0, core_reset});
        ev(8'h80);
        repeat (20) @(posedge clk);
        i_pins.pin_low(10);
        wait_for(1, 1, 30);
        chk("reset code", 8'h03, {4'h0, reset_cause});
        chk("rc clock", 8'h01, {7'h0, run_from_rc});
        wait_for(1, 0, 300);
        wait_for(0, 1, 300);
        $display("test resets done");
        wr(RWC_OFF_CONFIG, 8'h0c);
        i_pins.dip(5);
        wait_for(1, 1, 30);
        repeat (500) @(posedge clk);
        i_pins.dip(5);
        wait_for(1, 0, 20000);
        chk("timer restart", 8'h01, {7'h0, n >= 7100});
        chk("reset code", 8'h05, {4'h0, reset_cause});
        wait_for(0, 1, 300);
        rd(RWC_OFF_CAUSE, 8'h02, 8'h03);
        wr(RWC_OFF_CONFIG, 8'h08);
        wr(RWC_OFF_CAUSE, 8'h01);
        rd(RWC_OFF_CAUSE, 8'h00, 8'h01);
        repeat (3) @(posedge clk);
        $display("test brown-out done");
        results();
    end
endmodule : rwc_top_bench
